// File: swm_core.sv
// Top of the switch monitor: mode sequencing, sampling, clean-current pulse,
// event flags and the pin-side glue for the serial port and interrupt pin.
// Assumes comparator, fault and serial inputs are asynchronous to i_mclk.
`timescale 1ns/1ps
module swm_core #(
    parameter int INT_ACT_CYC = swm_pkg::INT_ACT_CYC,
    parameter int INT_INACT_CYC = swm_pkg::INT_INACT_CYC
) (
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_reset_pin,
    input wire logic i_trigger,
    input wire logic i_poll_mode,
    input wire logic [19:0] i_poll_period,
    input wire logic [19:0] i_poll_act,
    input wire logic [15:0] i_ccp_len,
    input wire logic [9:0] i_bat_sel,
    input wire logic [23:0] i_comp,
    input wire logic i_overvoltage_event,
    input wire logic i_undervoltage_event,
    input wire logic i_thermal_warning_event,
    input wire logic i_thermal_shutdown_event,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_si,
    output logic o_so,
    output logic o_so_oe_n,
    output logic o_int_o,
    output logic o_int_oe_n,
    output logic o_wetting_en,
    output logic o_ccp_en,
    output logic [23:0] o_sw_state
);
    localparam int NS = swm_pkg::N_IN + 5;
    localparam int IRQ_IDLE = swm_pkg::IDLE_CYC;

    // Pacer counters are 16 bits wide
    if (INT_ACT_CYC < 1 || INT_INACT_CYC < 1
        || INT_ACT_CYC > 65535 || INT_INACT_CYC > 65535) begin : g_prm
        $error("pacing parameters out of range");
    end

    swm_link_if lk();

    logic [NS-1:0] s1;
    logic [NS-1:0] s2;
    logic [3:0] flt_d;
    logic [3:0] flt_evt;
    logic [7:0] rst_cnt;
    logic srst;
    swm_pkg::swm_seq_t state;
    swm_pkg::swm_seq_t next_state;
    logic [19:0] cnt;
    logic [19:0] per_cnt;
    logic sample_now;
    logic have_prev;
    logic [23:0] closed;
    logic chg_evt;
    logic [swm_pkg::N_FLAGS-1:0] int_stat;
    logic [swm_pkg::N_FLAGS-1:0] next_int_stat;
    logic polling;

    // Ground switch closed pulls the pin low; battery switch pulls it high
    function automatic logic [23:0] swm_closed(input logic [23:0] comp,
                                               input logic [9:0] bat);
        logic [23:0] r;
        r = ~comp;
        for (int i = swm_pkg::N_GND; i < swm_pkg::N_IN; i++) begin
            if (bat[i - swm_pkg::N_GND]) begin
                r[i] = comp[i];
            end
        end
        return r;
    endfunction

    swm_spi u_spi (
        .i_mclk(i_mclk),
        .i_arst_n(i_arst_n),
        .i_sclk(i_sclk),
        .i_cs_n(i_cs_n),
        .i_si(i_si),
        .o_so(o_so),
        .o_so_oe_n(o_so_oe_n),
        .lk(lk.spi)
    );

    swm_irq #(
        .ACT_CYC(INT_ACT_CYC),
        .INACT_CYC(INT_INACT_CYC)
    ) u_irq (
        .i_mclk(i_mclk),
        .i_arst_n(i_arst_n),
        .lk(lk.irq)
    );

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s1 <= '0;
            s2 <= '0;
            flt_d <= 4'h0;
        end else begin
            s1 <= {i_reset_pin, i_thermal_shutdown_event, i_thermal_warning_event,
                   i_undervoltage_event, i_overvoltage_event, i_comp};
            s2 <= s1;
            flt_d <= s2[NS-2:swm_pkg::N_IN];
        end
    end

    assign flt_evt = s2[NS-2:swm_pkg::N_IN] & ~flt_d;
    assign closed = swm_closed(s2[23:0], i_bat_sel);

    // Short glitches on the reset pin are ignored; only a held level resets
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_cnt <= 8'h0;
            srst <= 1'b0;
        end else if (!s2[NS-1]) begin
            rst_cnt <= 8'h0;
            srst <= 1'b0;
        end else if (rst_cnt < 8'(swm_pkg::RSTPIN_CYC - 1)) begin
            rst_cnt <= rst_cnt + 8'h1;
        end else begin
            srst <= 1'b1;
        end
    end
    assign lk.srst = srst;

    assign polling = (state != swm_pkg::SQ_CONT) && (state != swm_pkg::SQ_IDLE);

    always_comb begin
        next_state = state;
        unique case (state)
            swm_pkg::SQ_IDLE: begin
                next_state = i_poll_mode ? swm_pkg::SQ_START : swm_pkg::SQ_CONT;
            end
            swm_pkg::SQ_START: begin
                if (cnt == 20'(swm_pkg::START_CYC - 1)) begin
                    next_state = swm_pkg::SQ_WAIT;
                end
            end
            swm_pkg::SQ_WAIT: begin
                if (cnt == 20'(swm_pkg::COMP_CYC - 1)) begin
                    next_state = swm_pkg::SQ_TRAN;
                end
            end
            swm_pkg::SQ_TRAN: begin
                if (cnt == 20'(swm_pkg::TRAN_CYC - 1)) begin
                    next_state = swm_pkg::SQ_CCP;
                end
            end
            swm_pkg::SQ_CCP: begin
                if (cnt >= {4'h0, i_ccp_len} - 20'h1) begin
                    next_state = swm_pkg::SQ_SLEEP;
                end
            end
            swm_pkg::SQ_SLEEP: begin
                if (per_cnt >= i_poll_period - 20'h1) begin
                    next_state = swm_pkg::SQ_WAIT;
                end
            end
            swm_pkg::SQ_CONT: begin
                next_state = swm_pkg::SQ_CONT;
            end
            default: begin
                next_state = swm_pkg::SQ_IDLE;
            end
        endcase
        if (srst || !i_trigger) begin
            next_state = swm_pkg::SQ_IDLE;
        end else if (state != swm_pkg::SQ_IDLE && polling != i_poll_mode) begin
            next_state = swm_pkg::SQ_IDLE;
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= swm_pkg::SQ_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // One timebase: every interval is a count of core clocks
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt <= 20'h0;
        end else if (next_state != state || sample_now) begin
            cnt <= 20'h0;
        end else begin
            cnt <= cnt + 20'h1;
        end
    end

    // Saturates so a long idle stretch never wraps back into the window
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            per_cnt <= 20'h0;
        end else if (next_state == swm_pkg::SQ_WAIT && state != swm_pkg::SQ_WAIT) begin
            per_cnt <= 20'h0;
        end else if (per_cnt != 20'hFFFFF) begin
            per_cnt <= per_cnt + 20'h1;
        end
    end

    // Continuous mode samples every detection time, polling once per window
    assign sample_now = (state == swm_pkg::SQ_WAIT || state == swm_pkg::SQ_CONT)
        && cnt == 20'(swm_pkg::COMP_CYC - 1) && next_state == state
        || state == swm_pkg::SQ_WAIT && next_state == swm_pkg::SQ_TRAN;

    // Wetting in polling only inside the active window, which holds the sample
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_wetting_en <= 1'b0;
            o_ccp_en <= 1'b0;
        end else begin
            o_wetting_en <= (next_state == swm_pkg::SQ_CONT)
                || (next_state == swm_pkg::SQ_WAIT)
                || ((next_state == swm_pkg::SQ_TRAN || next_state == swm_pkg::SQ_CCP
                     || next_state == swm_pkg::SQ_SLEEP)
                    && per_cnt + 20'h1 < i_poll_act);
            o_ccp_en <= (next_state == swm_pkg::SQ_CCP);
        end
    end

    // First sample after trigger only sets the baseline
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_sw_state <= 24'h0;
            have_prev <= 1'b0;
        end else if (srst) begin
            o_sw_state <= 24'h0;
            have_prev <= 1'b0;
        end else if (state == swm_pkg::SQ_IDLE) begin
            have_prev <= 1'b0;
        end else if (sample_now) begin
            o_sw_state <= closed;
            have_prev <= 1'b1;
        end
    end

    assign chg_evt = sample_now && have_prev && closed != o_sw_state;

    always_comb begin
        next_int_stat = lk.clr_int ? '0 : int_stat;
        next_int_stat[swm_pkg::FLG_CHG] = next_int_stat[swm_pkg::FLG_CHG] | chg_evt;
        next_int_stat[swm_pkg::FLG_TSD:swm_pkg::FLG_OV] =
            next_int_stat[swm_pkg::FLG_TSD:swm_pkg::FLG_OV] | flt_evt;
    end

    // A new event in the clearing cycle survives the clear
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            int_stat <= '0;
        end else if (srst) begin
            int_stat <= '0;
        end else begin
            int_stat <= next_int_stat;
        end
    end

    assign lk.pending = |int_stat;
    assign lk.tx_word = {3'h0, int_stat, o_sw_state};

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_int_o <= 1'b0;
            o_int_oe_n <= 1'b1;
        end else begin
            o_int_o <= 1'b0;
            o_int_oe_n <= ~lk.int_low;
        end
    end

    // Checks count core clocks, as the sequencer does
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);
    comp_wait_a: assert property (sample_now && state == swm_pkg::SQ_WAIT |->
        $past(state, swm_pkg::COMP_CYC - 1) == swm_pkg::SQ_WAIT
        && $past(state, swm_pkg::COMP_CYC) != swm_pkg::SQ_WAIT)
        else $error("sample before detection time");
    ccp_start_a: assert property ($rose(o_ccp_en) |->
        $past(state, swm_pkg::TRAN_CYC + 1) == swm_pkg::SQ_WAIT
        && $past(state, swm_pkg::TRAN_CYC) == swm_pkg::SQ_TRAN)
        else $error("clean current started at wrong time");
    startup_a: assert property (state == swm_pkg::SQ_WAIT
        && $past(state) == swm_pkg::SQ_START
        |-> $past(cnt) == 20'(swm_pkg::START_CYC - 1)) else $error("startup length wrong");
    trig_off_a: assert property (!i_trigger ##1 !i_trigger |=>
        !o_wetting_en && !o_ccp_en && state == swm_pkg::SQ_IDLE)
        else $error("monitoring active without trigger");
    change_irq_a: assert property (chg_evt && !srst |=> int_stat[swm_pkg::FLG_CHG]
        ##[1:IRQ_IDLE] lk.pending) else $error("change not flagged");
    set_wins_a: assert property (lk.clr_int && |flt_evt && !srst |=> lk.pending)
        else $error("event lost in clearing cycle");
    cont_wait_a: assert property (sample_now && state == swm_pkg::SQ_CONT |->
        $past(state, swm_pkg::COMP_CYC - 1) == swm_pkg::SQ_CONT)
        else $error("continuous sample before detection time");
    wet_off_a: assert property (state == swm_pkg::SQ_SLEEP && per_cnt >= i_poll_act |->
        !o_wetting_en) else $error("wetting on outside the active window");
    poll_ccp_c: cover property ($rose(o_ccp_en) ##1 o_ccp_en);
    cont_sample_c: cover property (state == swm_pkg::SQ_CONT && chg_evt);
    clear_c: cover property (lk.clr_int && lk.int_low);
endmodule

// File: swm_core_tb.sv
// Self-checking bench for the switch monitor core with the host model.
// Assumes short interrupt pulse counts, set through the core's parameters.
`timescale 1ns/1ps
module swm_core_tb;
    logic i_mclk = 1'b0, i_arst_n = 1'b0, rst_pin = 1'b0, trig = 1'b0, pmode = 1'b0;
    logic [23:0] comp = 24'hFFBFFF;
    logic [9:0] bsel = 10'h001;
    logic [3:0] ev = 4'h0;
    logic [31:0] w;
    logic drv;
    wire sclk, cs_n, si, so, so_oe_n, int_oe_n, wet, ccp_en;
    wire [23:0] sw;
    int failures = 0, cmp_count = 0, n, m, p;
    always #50 i_mclk = ~i_mclk;
    swm_core #(.INT_ACT_CYC(40), .INT_INACT_CYC(60)) swm_core_i (.i_mclk(i_mclk),
        .i_arst_n(i_arst_n), .i_reset_pin(rst_pin), .i_trigger(trig), .i_poll_mode(pmode),
        .i_poll_period(20'h003E8), .i_poll_act(20'h0012C), .i_ccp_len(16'h0032),
        .i_bat_sel(bsel), .i_comp(comp), .i_overvoltage_event(ev[0]),
        .i_undervoltage_event(ev[1]), .i_thermal_warning_event(ev[2]),
        .i_thermal_shutdown_event(ev[3]), .i_sclk(sclk), .i_cs_n(cs_n), .i_si(si),
        .o_so(so), .o_so_oe_n(so_oe_n), .o_int_o(), .o_int_oe_n(int_oe_n),
        .o_wetting_en(wet), .o_ccp_en(ccp_en), .o_sw_state(sw));
    swm_host swm_host_i (.i_mclk(i_mclk), .i_so(so), .i_so_oe_n(so_oe_n), .o_sclk(sclk),
        .o_cs_n(cs_n), .o_si(si));
    function automatic logic sig(int s);
        case (s)
            0: return int_oe_n;
            1: return wet;
            default: return ccp_en;
        endcase
    endfunction
    task automatic wait_sig(int s, logic v, int lim, output int c);
        c = 0;
        while (sig(s) !== v && c < lim) begin
            @(negedge i_mclk);
            c++;
        end
    endtask
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(int got, int lo, int hi);
        cmp_count++;
        if (got < lo || got > hi) begin
            failures++;
            $display("unexpected at %0t: got %h range %h to %h", $time, got, lo, hi);
        end
    endtask
    task complete_run;
        $display("Checks %0d, failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task t_reset;
        chk({int_oe_n, so_oe_n, wet, ccp_en, sw}, 32'h0C000000);
        repeat (2) @(negedge i_mclk);
        chk({int_oe_n, so_oe_n, wet, ccp_en, sw}, 32'h0C000000);
    endtask
    task t_cont;
        trig = 1'b1;
        wait_sig(1, 1'b1, 10, n);
        chk_rng(n, 0, 9);
        repeat (400) @(negedge i_mclk);
        chk(int_oe_n, 1'b1);
        comp = 24'hFFFFFE;
        wait_sig(0, 1'b0, 2000, n);
        chk_rng(n, 0, 1999);
        wait_sig(0, 1'b1, 100, n);
        chk_rng(n, 39, 41);
        wait_sig(0, 1'b0, 100, n);
        chk_rng(n, 59, 61);
        swm_host_i.frame(1'b0, w, drv);
        chk(w, 32'h01004001);
        chk({drv, so_oe_n}, 2'h3);
        wait_sig(0, 1'b0, 101, n);
        chk_rng(n, 0, 100);
        swm_host_i.frame(1'b1, w, drv);
        chk(w, 32'h01004001);
        wait_sig(0, 1'b0, 200, n);
        chk_rng(n, 200, 200);
        trig = 1'b0;
        wait_sig(1, 1'b0, 5, n);
        chk_rng(n, 0, 4);
    endtask
    task t_poll;
        pmode = 1'b1;
        repeat (2) @(negedge i_mclk);
        trig = 1'b1;
        wait_sig(1, 1'b1, 4000, n);
        chk_rng(n, swm_pkg::START_CYC, swm_pkg::START_CYC + 5);
        wait_sig(2, 1'b1, 1000, m);
        chk_rng(m, swm_pkg::COMP_CYC + swm_pkg::TRAN_CYC - 2,
            swm_pkg::COMP_CYC + swm_pkg::TRAN_CYC + 3);
        wait_sig(2, 1'b0, 100, p);
        chk_rng(p, 49, 51);
        wait_sig(1, 1'b1, 2000, n);
        chk_rng(m + p + n, 998, 1002);
        wait_sig(1, 1'b0, 400, n);
        chk_rng(n, 299, 301);
    endtask
    task t_fault;
        for (int k = 0; k < 4; k++) begin
            ev[k] = 1'b1;
            wait_sig(0, 1'b0, 2000, n);
            if (k == 0)
                chk_rng(n, 0, swm_pkg::REACT_CYC);
            else
                chk_rng(n, swm_pkg::IDLE_CYC - 30, swm_pkg::IDLE_CYC + 200);
            swm_host_i.frame(1'b1, w, drv);
            chk(w[31:24], 8'h01 << (k + 1));
            ev[k] = 1'b0;
        end
    endtask
    task t_pin;
        ev[0] = 1'b1;
        wait_sig(0, 1'b0, 2000, n);
        chk_rng(n, 0, 1999);
        rst_pin = 1'b1;
        wait_sig(0, 1'b1, 10001, n);
        chk_rng(n, 0, 10000);
        repeat (30) @(negedge i_mclk);
        chk({int_oe_n, wet, sw}, 32'h02000000);
        rst_pin = 1'b0;
    endtask
    initial begin
        repeat (4) @(negedge i_mclk);
        i_arst_n = 1'b1;
        t_reset;
        t_cont;
        t_poll;
        t_fault;
        t_pin;
        complete_run;
    end
    // Whole run needs about 11000 cycles; the 50000-cycle limit is a hang
    initial begin
        #5000000;
        failures++;
        complete_run;
    end
endmodule

// File: swm_host.sv
// Host model: serial master that reads the status word of the switch monitor.
// Assumes the core clock only paces its edges; the link clock rests low between frames.
`timescale 1ns/1ps
module swm_host (
    input wire logic i_mclk,
    input wire logic i_so,
    input wire logic i_so_oe_n,
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_si
);
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b0;
    end
    // Four core cycles a half period make the 800 ns link clock
    task automatic frame(input logic rd, output logic [31:0] w, output logic drv);
        w = 32'h0;
        drv = 1'b1;
        @(negedge i_mclk);
        o_cs_n = 1'b0;
        repeat (4) @(negedge i_mclk);
        for (int i = 0; i < 32; i++) begin
            o_sclk = 1'b1;
            o_si = (i == 0) ? rd : ~o_si;
            repeat (4) @(negedge i_mclk);
            o_sclk = 1'b0;
            // Taken late in the low half, where the bit has settled
            repeat (4) @(negedge i_mclk);
            w = {w[30:0], i_so};
            drv = drv & (i_so_oe_n === 1'b0);
        end
        o_cs_n = 1'b1;
        o_si = ~o_si;
        repeat (20) @(negedge i_mclk);
    endtask
endmodule

// File: swm_irq.sv
// Interrupt pacer: idle gap, active-low pulse, release gap while still pending.
// Assumes pending and clear come from the same clock; clear is a one-cycle pulse.
`timescale 1ns/1ps
module swm_irq #(
    parameter int ACT_CYC = swm_pkg::INT_ACT_CYC,
    parameter int INACT_CYC = swm_pkg::INT_INACT_CYC
) (
    input wire logic i_mclk,
    input wire logic i_arst_n,
    swm_link_if.irq lk
);
    swm_pkg::swm_irq_t st;
    logic [15:0] cnt;
    logic idle_done;

    if (ACT_CYC < 1 || INACT_CYC < 1 || ACT_CYC > 65535 || INACT_CYC > 65535) begin : g_chk
        $error("interrupt pacing counts out of range");
    end

    assign idle_done = cnt >= 16'(swm_pkg::IDLE_CYC - 1);
    assign lk.int_low = (st == swm_pkg::IQ_LOW);

    // Clearing outside idle drops back to idle so a later event gets a full pulse
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st <= swm_pkg::IQ_IDLE;
            cnt <= 16'h0;
        end else if (lk.srst || (lk.clr_int && st != swm_pkg::IQ_IDLE)) begin
            st <= swm_pkg::IQ_IDLE;
            cnt <= 16'h0;
        end else begin
            unique case (st)
                swm_pkg::IQ_IDLE: begin
                    if (lk.pending && idle_done) begin
                        st <= swm_pkg::IQ_LOW;
                        cnt <= 16'h0;
                    end else if (!idle_done) begin
                        cnt <= cnt + 16'h1;
                    end
                end
                swm_pkg::IQ_LOW: begin
                    if (cnt == 16'(ACT_CYC - 1)) begin
                        st <= swm_pkg::IQ_HIGH;
                        cnt <= 16'h0;
                    end else begin
                        cnt <= cnt + 16'h1;
                    end
                end
                swm_pkg::IQ_HIGH: begin
                    if (cnt == 16'(INACT_CYC - 1)) begin
                        st <= swm_pkg::IQ_LOW;
                        cnt <= 16'h0;
                    end else begin
                        cnt <= cnt + 16'h1;
                    end
                end
                default: begin
                    st <= swm_pkg::IQ_IDLE;
                    cnt <= 16'h0;
                end
            endcase
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);
    act_pulse_a: assert property ($fell(lk.int_low) && !$past(lk.clr_int) && !$past(lk.srst)
        |-> $past(cnt) == 16'(ACT_CYC - 1)) else $error("active pulse length wrong");
    inact_gap_a: assert property ($rose(lk.int_low) && $past(st) == swm_pkg::IQ_HIGH
        |-> $past(cnt) == 16'(INACT_CYC - 1)) else $error("release gap length wrong");
    idle_gap_a: assert property ($rose(lk.int_low) && $past(st) == swm_pkg::IQ_IDLE
        |-> $past(cnt) >= 16'(swm_pkg::IDLE_CYC - 1)) else $error("idle gap too short");
    react_fast_a: assert property (lk.pending && st == swm_pkg::IQ_IDLE && idle_done
        && !lk.srst |=> lk.int_low) else $error("interrupt not asserted promptly");
    clr_release_a: assert property (lk.clr_int && lk.int_low |=> !lk.int_low ##1
        st == swm_pkg::IQ_IDLE || lk.int_low) else $error("clear did not release");
    pulse_seen_c: cover property ($fell(lk.int_low) ##1 !lk.int_low [*8]);
    repeat_pulse_c: cover property ($rose(lk.int_low) && $past(st) == swm_pkg::IQ_HIGH);
endmodule

// File: swm_link_if.sv
// Carrier between the core, its serial port and its interrupt pacer.
// Assumes all three sit on the same core clock.
`timescale 1ns/1ps
interface swm_link_if;
    logic [31:0] tx_word;
    logic clr_int;
    logic pending;
    logic srst;
    logic int_low;
    modport core(output tx_word, output pending, output srst, input clr_int, input int_low);
    modport spi(input tx_word, output clr_int);
    modport irq(input pending, input clr_int, input srst, output int_low);
endinterface

// File: swm_pkg.sv
// Shared constants and types for the switch monitor sequencing and interrupt core.
// Assumes a 10 MHz core clock; all timing counts are derived from it here.
package swm_pkg;
    localparam int CLK_NS = 100;
    localparam int N_IN = 24;
    localparam int N_GND = 14;
    localparam int N_PROG = 10;
    localparam int T_COMP_NS = 18000;
    localparam int COMP_CYC = T_COMP_NS / CLK_NS;
    localparam int T_TRAN_NS = 20000;
    localparam int TRAN_CYC = T_TRAN_NS / CLK_NS;
    localparam int T_START_NS = 300000;
    localparam int START_CYC = T_START_NS / CLK_NS;
    localparam int T_IDLE_NS = 100000;
    localparam int IDLE_CYC = T_IDLE_NS / CLK_NS;
    localparam int T_INT_ACT_US = 2000;
    localparam int INT_ACT_CYC = T_INT_ACT_US * 1000 / CLK_NS;
    localparam int T_INT_INACT_US = 4000;
    localparam int INT_INACT_CYC = T_INT_INACT_US * 1000 / CLK_NS;
    localparam int T_REACT_NS = 20000;
    localparam int REACT_CYC = T_REACT_NS / CLK_NS;
    localparam int T_RSTPIN_NS = 2000;
    localparam int RSTPIN_CYC = (T_RSTPIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int FRAME_BITS = 32;
    localparam int FLAG_LSB = 24;
    localparam int N_FLAGS = 5;
    localparam int FLG_CHG = 0;
    localparam int FLG_OV = 1;
    localparam int FLG_UV = 2;
    localparam int FLG_TW = 3;
    localparam int FLG_TSD = 4;
    typedef enum logic [2:0] {
        SQ_IDLE = 3'h0, SQ_START = 3'h1, SQ_WAIT = 3'h2, SQ_TRAN = 3'h3,
        SQ_CCP = 3'h4, SQ_SLEEP = 3'h5, SQ_CONT = 3'h6
    } swm_seq_t;
    typedef enum logic [1:0] {
        IQ_IDLE = 2'h0, IQ_LOW = 2'h1, IQ_HIGH = 2'h2
    } swm_irq_t;
endpackage

// File: swm_spi.sv
// Serial slave: shifts out the status word, catches the read flag in the first bit.
// Assumes serial pins are asynchronous and far slower than the core clock.
`timescale 1ns/1ps
module swm_spi (
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_si,
    output logic o_so,
    output logic o_so_oe_n,
    swm_link_if.spi lk
);
    logic [2:0] s1;
    logic [2:0] s2;
    logic sclk_d;
    logic cs_d;
    logic [31:0] tx;
    logic first;
    logic rd;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            // Idle levels: select high, clock low, so no false edge after reset
            s1 <= 3'h4;
            s2 <= 3'h4;
            sclk_d <= 1'b0;
            cs_d <= 1'b1;
        end else begin
            s1 <= {i_cs_n, i_sclk, i_si};
            s2 <= s1;
            sclk_d <= s2[1];
            cs_d <= s2[2];
        end
    end

    assign sclk_rise = s2[1] & ~sclk_d;
    assign sclk_fall = ~s2[1] & sclk_d;
    assign cs_fall = ~s2[2] & cs_d;
    assign cs_rise = s2[2] & ~cs_d;

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tx <= 32'h0;
            o_so <= 1'b0;
            first <= 1'b0;
            rd <= 1'b0;
        end else if (cs_fall) begin
            tx <= lk.tx_word;
            first <= 1'b1;
            rd <= 1'b0;
        end else if (!s2[2]) begin
            if (sclk_rise) begin
                o_so <= tx[31];
                tx <= {tx[30:0], 1'b0};
            end
            if (sclk_fall && first) begin
                rd <= s2[0];
                first <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            lk.clr_int <= 1'b0;
            o_so_oe_n <= 1'b1;
        end else begin
            lk.clr_int <= cs_rise & rd;
            o_so_oe_n <= s2[2];
        end
    end

    so_hiz_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        s2[2] |=> o_so_oe_n) else $error("serial output driven with select high");
    clr_read_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        lk.clr_int |-> $past(rd) && $past(cs_rise)) else $error("clear without read");
endmodule
